// [hdl/command_reset_handshake.sv]
// Command and abort handshake of the interface module, seen from the
// fieldbus side: samples request bits per telegram, drives ack bits.
// Assumes telegram_strobe is a one-cycle pulse from logic on core_clk;
// presence_in comes from a pin and is synchronised here.
// Completion and results come from firmware over the register port.
`timescale 1ns/1ns

// Notes on behaviour
// - Commands move by request/acknowledge handshake across independent cycles.
// - Abort uses its own request and acknowledge pair.
// - Without new results the previous response telegram is resent.
// - Live presence state always appears in the outgoing command byte.
// - Seeing a set request, module clears the matching acknowledge bit.
// - On completion module sets the acknowledge again, ready for next.
// - Any started command can be aborted by an abort request.
// - While abort acknowledge is cleared, further abort requests are rejected.
// - Both requests set in one bus cycle: only the abort acts.
// - From abort request seen to abort acknowledge, command request ignored.
// - Abort after accepted command: both acks rise together at abort end.
// - Aborted command returns only the abort result telegram; a done write in the abort's cycle still publishes the command result.
module command_reset_handshake
    import cmd_handshake_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    input  wire logic        telegram_strobe,
    input  wire request_s    request_in,
    input  wire logic        presence_in,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [15:0]      reg_rdata,
    output telegram_s        telegram_out,
    output logic             cmd_start,
    output logic             abort_start
);

    // Every register below holds while clk_en is low; a telegram strobe
    // that falls in such a cycle is lost, so the source must hold off.

    // ------------------------------------------------------------
    // Presence synchroniser
    // ------------------------------------------------------------
    // Three stages: a change is taken once stage two and three agree.
    // Reset value matches the absent level of the pin, so no false
    // presence edge is reported right after reset.
    // Limitation: a pulse shorter than two clocks may never be seen.
    logic [2:0] pres_sync;
    logic       presence;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pres_sync <= 3'b000;
        end else if (clk_en) begin
            pres_sync <= {pres_sync[1:0], presence_in};
        end
    end

    // Agreement of stages two and three filters a level still settling
    wire pres_agree = (pres_sync[1] == pres_sync[2]);

    // Filtered level; holds its last value while the stages differ
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            presence <= 1'b0;
        end else if (clk_en && pres_agree) begin
            presence <= pres_sync[2];
        end
    end

    // ------------------------------------------------------------
    // Request sampling
    // ------------------------------------------------------------
    // Request bits are only looked at when a telegram arrives; between
    // telegrams the lines may carry anything and are ignored.
    // Only rising edges start work, so a level the user leaves high
    // never starts a second command or abort.
    request_s req_now;
    request_s req_prev;

    // Current and previous telegram samples
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            req_now  <= '0;
            req_prev <= '0;
        end else if (clk_en && telegram_strobe) begin
            req_prev <= req_now;
            req_now  <= request_in;
        end
    end

    // Sample pulse one cycle after the strobe, once req_now is fresh
    // Trade-off: one cycle of latency buys a clean compare of two
    // registered samples instead of a compare against the raw lines.
    logic sample_pulse;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sample_pulse <= 1'b0;
        end else if (clk_en) begin
            sample_pulse <= telegram_strobe;
        end
    end

    wire cmd_rise   = sample_pulse && req_now.cmd_request && !req_prev.cmd_request;
    wire abort_rise = sample_pulse && req_now.abort_request && !req_prev.abort_request;
    // Both rises come from the same pair of samples, which lets the
    // machine see a joint command and abort as one event.

    // ------------------------------------------------------------
    // Handshake state machine
    // ------------------------------------------------------------
    hs_state_e state;
    hs_state_e next_state;
    logic      cmd_ack;
    logic      abort_ack;
    logic      next_cmd_ack;
    logic      next_abort_ack;
    logic      cmd_done_req;
    logic      abort_done_req;
    logic      aborted_cmd;
    logic      next_aborted_cmd;

    // State decode shared by the transitions, start pulses and status
    wire in_idle  = (state == ST_IDLE);
    wire in_cmd   = (state == ST_CMD);
    wire in_abort = (state == ST_ABORT);

    // An abort is refused while its own acknowledge is still low, so a
    // running abort can never be cut short by a second one.
    // A command needs an idle machine and loses to an abort seen in the
    // same telegram; while an abort runs the machine is not idle, which
    // masks the command request until the abort acknowledge rises.
    // Command accepted only when idle and not masked by an abort
    wire accept_abort = abort_rise && abort_ack;
    wire accept_cmd   = cmd_rise && !abort_rise && cmd_ack
                        && in_idle;

    // Transitions. Completion writes from software end a command or an
    // abort; an abort taken during a command marks it, so that its result
    // is never published unless the done write falls in that same cycle, and both acknowledges rise together at the end.
    always_comb begin
        next_state       = state;
        next_cmd_ack     = cmd_ack;
        next_abort_ack   = abort_ack;
        next_aborted_cmd = aborted_cmd;
        case (state)
            ST_IDLE: begin
                if (accept_abort) begin
                    next_state     = ST_ABORT;
                    next_abort_ack = 1'b0;
                end else if (accept_cmd) begin
                    next_state   = ST_CMD;
                    next_cmd_ack = 1'b0;
                end
            end
            ST_CMD: begin
                // An abort wins over a done write in the same cycle
                if (accept_abort) begin
                    next_state       = ST_ABORT;
                    next_abort_ack   = 1'b0;
                    next_aborted_cmd = 1'b1;
                end else if (cmd_done_req) begin
                    next_state   = ST_IDLE;
                    next_cmd_ack = 1'b1;
                end
            end
            ST_ABORT: begin
                // Abort done releases both acks together, cut command or not
                if (abort_done_req) begin
                    next_state       = ST_IDLE;
                    next_abort_ack   = 1'b1;
                    next_cmd_ack     = 1'b1;
                    next_aborted_cmd = 1'b0;
                end
            end
            default: begin
                // Illegal code: fall back to idle, acks as they stand
                next_state = ST_IDLE;
            end
        endcase
    end

    // Both acknowledges reset high: the block is ready for a command and
    // an abort as soon as reset is released.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state       <= ST_IDLE;
            cmd_ack     <= 1'b1;
            abort_ack   <= 1'b1;
            aborted_cmd <= 1'b0;
        end else if (clk_en) begin
            state       <= next_state;
            cmd_ack     <= next_cmd_ack;
            abort_ack   <= next_abort_ack;
            aborted_cmd <= next_aborted_cmd;
        end
    end

    // Start pulses toward the execution logic; registered so that they
    // rise on the same edge as the matching acknowledge falls.
    wire next_cmd_start   = in_idle && accept_cmd && !accept_abort;
    wire next_abort_start = !in_abort && accept_abort;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cmd_start   <= 1'b0;
            abort_start <= 1'b0;
        end else if (clk_en) begin
            cmd_start   <= next_cmd_start;
            abort_start <= next_abort_start;
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // Software (the execution firmware) reports completion and results.
    // Completion bits only act in the matching busy state, so a stray or
    // late done write cannot end a request that was never accepted.
    // Results must be written before the done bit: the telegram copies
    // the result register on the edge that takes the done write.
    logic [15:0] cmd_result;
    logic [15:0] abort_result;
    logic [15:0] cmd_count;

    // Write decode
    wire wr_control  = reg_write && (reg_addr == ADDR_CONTROL);
    wire wr_result   = reg_write && (reg_addr == ADDR_RESULT);
    wire wr_abortres = reg_write && (reg_addr == ADDR_ABORT_RES);

    assign cmd_done_req   = wr_control && reg_wdata[CTRL_DONE_BIT] && (state == ST_CMD);
    assign abort_done_req = wr_control && reg_wdata[CTRL_ADONE_BIT] && (state == ST_ABORT);

    // Result registers are plain storage; they publish only on completion
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cmd_result   <= ZERO_WORD;
            abort_result <= ZERO_WORD;
        end else if (clk_en) begin
            if (wr_result) begin
                cmd_result <= reg_wdata;
            end
            if (wr_abortres) begin
                abort_result <= reg_wdata;
            end
        end
    end

    // Counts accepted commands; wraps silently, software reads a delta
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cmd_count <= ZERO_WORD;
        end else if (clk_en && cmd_start) begin
            cmd_count <= cmd_count + 16'h0001;
        end
    end

    // Status mirrors the live handshake so firmware can poll instead of
    // watching the start pulses.
    logic [15:0] status_word;

    always_comb begin
        status_word                 = ZERO_WORD;
        status_word[STAT_BUSY_BIT]  = in_cmd;
        status_word[STAT_ABUSY_BIT] = in_abort;
        status_word[STAT_CACK_BIT]  = cmd_ack;
        status_word[STAT_AACK_BIT]  = abort_ack;
        status_word[STAT_PRES_BIT]  = presence;
    end

    // Unmapped and write-only addresses read as zero; read data stand for
    // one cycle only and are zero otherwise, so stale data never linger.
    wire [15:0] read_mux = (reg_addr == ADDR_STATUS)    ? status_word  :
                           (reg_addr == ADDR_RESULT)    ? cmd_result   :
                           (reg_addr == ADDR_ABORT_RES) ? abort_result :
                           (reg_addr == ADDR_CMD_SEEN)  ? cmd_count    :
                           ZERO_WORD;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= ZERO_WORD;
        end else if (clk_en) begin
            reg_rdata <= reg_read ? read_mux : ZERO_WORD;
        end
    end

    // ------------------------------------------------------------
    // Outgoing telegram
    // ------------------------------------------------------------
    // Result is latched only at completion, so between completions the
    // previous response stands; an aborted command publishes only if its done write falls in the abort's cycle.
    // The abort result replaces whatever the command had written, which
    // is how a cut command is hidden from the user by the end of the abort.
    logic [15:0] held_result;
    logic [15:0] next_held_result;

    // Held value only moves on a done write in the matching state
    always_comb begin
        next_held_result = held_result;
        if (cmd_done_req && !aborted_cmd) begin
            next_held_result = cmd_result;
        end else if (abort_done_req) begin
            next_held_result = abort_result;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            held_result <= ZERO_WORD;
        end else if (clk_en) begin
            held_result <= next_held_result;
        end
    end

    // Command byte: presence is taken live every cycle, even before any
    // command; the acknowledges use their next values so that the byte and
    // the internal state change on the same edge and never disagree.
    // Unused bits stay zero.
    logic [7:0] next_cmd_byte;

    always_comb begin
        next_cmd_byte                = ZERO_BYTE;
        next_cmd_byte[CMD_PRES_BIT]  = presence;
        next_cmd_byte[CMD_ACK_BIT]   = next_cmd_ack;
        next_cmd_byte[ABORT_ACK_BIT] = next_abort_ack;
    end

    // Whole telegram is registered, so the fieldbus side never sees a
    // half-updated byte against a new result word.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            telegram_out <= '0;
        end else if (clk_en) begin
            telegram_out.cmd_byte <= next_cmd_byte;
            telegram_out.result   <= next_held_result;
        end
    end

endmodule

// [include/cmd_handshake_pkg.sv]
// Shared constants and types for the command/abort handshake block.
// Assumes one core clock; telegram fields arrive as loose bits.
package cmd_handshake_pkg;

    // ------------------------------------------------------------
    // Register map (plain port, word addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CONTROL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS    = 4'h1;
    localparam logic [3:0] ADDR_RESULT    = 4'h2;
    localparam logic [3:0] ADDR_ABORT_RES = 4'h3;
    localparam logic [3:0] ADDR_CMD_SEEN  = 4'h4;

    localparam int CTRL_DONE_BIT  = 0;
    localparam int CTRL_ADONE_BIT = 1;

    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_ABUSY_BIT = 1;
    localparam int STAT_CACK_BIT  = 2;
    localparam int STAT_AACK_BIT  = 3;
    localparam int STAT_PRES_BIT  = 4;

    localparam logic [15:0] ZERO_WORD  = 16'h0000;
    localparam logic [7:0]  ZERO_BYTE  = 8'h00;
    localparam int          CMD_PRES_BIT = 0;
    localparam int          CMD_ACK_BIT  = 6;
    localparam int          ABORT_ACK_BIT = 7;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CMD   = 3'b010,
        ST_ABORT = 3'b100
    } hs_state_e;

    typedef struct packed {
        logic cmd_request;
        logic abort_request;
    } request_s;

    typedef struct packed {
        logic [7:0]  cmd_byte;
        logic [15:0] result;
    } telegram_s;

endpackage

// [test/command_reset_handshake_properties.sv]
// Concurrent checks on the ports of the command/abort handshake block.
// Assumes one clock domain and the package compiled first.
`timescale 1ns/1ns
module command_reset_handshake_properties
    import cmd_handshake_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        presence_in,
    input wire logic        reg_write,
    input wire telegram_s   telegram_out,
    input wire logic        cmd_start,
    input wire logic        abort_start
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire logic cack = telegram_out.cmd_byte[CMD_ACK_BIT];
    wire logic aack = telegram_out.cmd_byte[ABORT_ACK_BIT];

    a_cmd_ack_clear: assert property (cmd_start |-> !cack)
        else $error("cmd ack not cleared on accept");
    a_abort_ack_clear: assert property (abort_start |-> !aack)
        else $error("abort ack not cleared on accept");
    a_ack_fall_cause: assert property ($fell(cack) |-> cmd_start)
        else $error("cmd ack fell without an accepted command");
    a_abort_reject: assert property (!$past(aack) |-> !abort_start)
        else $error("abort accepted while abort ack cleared");
    a_one_start_only: assert property (!(cmd_start && abort_start))
        else $error("command and abort accepted together");
    a_acks_together: assert property ($rose(cack) |-> $past(aack) || $rose(aack))
        else $error("cmd ack rose during abort");
    a_result_hold: assert property ($changed(telegram_out.result) |-> $past(reg_write))
        else $error("result changed without completion");
    a_presence_live: assert property ($stable(presence_in)[*8]
        |-> telegram_out.cmd_byte[CMD_PRES_BIT] == presence_in)
        else $error("presence bit not live");
endmodule

bind command_reset_handshake command_reset_handshake_properties i_props (
    .core_clk(core_clk), .resetn(resetn), .presence_in(presence_in), .reg_write(reg_write),
    .telegram_out(telegram_out), .cmd_start(cmd_start), .abort_start(abort_start));

// [test/field_master_model.sv]
// Cyclic fieldbus master: one telegram every period cycles.
// Assumes the bench sets the request levels the master should send.
`timescale 1ns/1ns
module field_master_model
    import cmd_handshake_pkg::*;
#(
    parameter int PERIOD = 4
)
(
    input  wire logic     core_clk,
    input  wire logic     resetn,
    input  wire request_s want,
    output logic          telegram_strobe,
    output request_s      request_in
);
    int tick;
    // Lines toggle between telegrams so a stale level never looks valid
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tick            <= 0;
            telegram_strobe <= 1'b0;
            request_in      <= '0;
        end else begin
            tick            <= (tick == PERIOD - 1) ? 0 : tick + 1;
            telegram_strobe <= (tick == 0);
            request_in      <= (tick == 0) ? want : ~request_in;
        end
    end
endmodule

// [test/tb_top.sv]
// Bench: master model polls the block, tasks drive the register port.
// Assumes package, checker and master model are compiled first.
`timescale 1ns/1ns
module tb_top;
    import cmd_handshake_pkg::*;
    localparam int PER = 4;
    logic        core_clk    = 1'b0;
    logic        resetn      = 1'b0;
    logic        clk_en      = 1'b1;
    logic        presence_in = 1'b0;
    logic [3:0]  reg_addr    = 4'h0;
    logic [15:0] reg_wdata   = 16'h0000;
    logic        reg_write   = 1'b0;
    logic        reg_read    = 1'b0;
    request_s    want        = '0;
    logic        telegram_strobe;
    request_s    request_in;
    logic [15:0] reg_rdata;
    telegram_s   telegram_out;
    logic        cmd_start;
    logic        abort_start;
    logic [15:0] rd;
    int          n_mismatch  = 0;
    int          checks_done = 0;
    int          n_cmd       = 0;
    int          n_abort     = 0;

    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (cmd_start === 1'b1) n_cmd++;
        if (abort_start === 1'b1) n_abort++;
    end

    field_master_model #(.PERIOD(PER)) i_master (.core_clk(core_clk), .resetn(resetn),
        .want(want), .telegram_strobe(telegram_strobe), .request_in(request_in));
    command_reset_handshake i_dut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
        .telegram_strobe(telegram_strobe), .request_in(request_in), .presence_in(presence_in),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .telegram_out(telegram_out),
        .cmd_start(cmd_start), .abort_start(abort_start));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_byte(input logic [7:0] exp);
        @(posedge core_clk);
        #1;
        chk("cmd_byte", {8'h00, exp}, {8'h00, telegram_out.cmd_byte});
    endtask
    task automatic req(input logic c, input logic a);
        @(posedge core_clk);
        want <= '{c, a};
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask
    // Start pulses stand one cycle, so poll just after every edge
    task automatic wait_start(input bit ab);
        int i;
        for (i = 0; i < 40; i++) begin
            @(posedge core_clk);
            #1;
            if ((ab ? abort_start : cmd_start) === 1'b1) break;
        end
        if (i == 40) begin
            n_mismatch++;
            $display("[FAIL] start pulse expected 1 seen 0");
        end
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        chk_byte(8'hc0);
        req(1'b1, 1'b0);
        wait_start(1'b0);
        chk_byte(8'h80);
        req(1'b0, 1'b0);
        repeat (3 * PER) @(posedge core_clk);
        chk_byte(8'h80);
        wr(ADDR_RESULT, 16'h1234);
        wr(ADDR_CONTROL, 16'h0001);
        chk_byte(8'hc0);
        chk("result", 16'h1234, telegram_out.result);
        $display("test command done");
        req(1'b1, 1'b0);
        wait_start(1'b0);
        req(1'b1, 1'b1);
        wait_start(1'b1);
        chk_byte(8'h00);
        req(1'b0, 1'b0);
        repeat (2 * PER) @(posedge core_clk);
        req(1'b0, 1'b1);
        repeat (3 * PER) @(posedge core_clk);
        chk("abort starts", 16'h0001, 16'(n_abort));
        wr(ADDR_RESULT, 16'h5678);
        wr(ADDR_ABORT_RES, 16'h0a0a);
        req(1'b0, 1'b0);
        wr(ADDR_CONTROL, 16'h0002);
        chk_byte(8'hc0);
        chk("result", 16'h0a0a, telegram_out.result);
        $display("test abort after command done");
        req(1'b1, 1'b1);
        wait_start(1'b1);
        chk_byte(8'h40);
        req(1'b0, 1'b0);
        repeat (2 * PER) @(posedge core_clk);
        req(1'b1, 1'b0);
        repeat (3 * PER) @(posedge core_clk);
        chk("cmd starts", 16'h0002, 16'(n_cmd));
        wr(ADDR_CONTROL, 16'h0002);
        chk_byte(8'hc0);
        req(1'b0, 1'b0);
        $display("test joint requests done");
        @(posedge core_clk);
        presence_in <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk_byte(8'hc1);
        rd_reg(ADDR_STATUS);
        chk("status", 16'h001c, rd);
        rd_reg(ADDR_CMD_SEEN);
        chk("cmd count", 16'h0002, rd);
        rd_reg(4'hf);
        chk("unmapped", 16'h0000, rd);
        $display("test presence and registers done");
        // A write while the clock enable is low must leave no trace
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr(ADDR_RESULT, 16'hbeef);
        clk_en <= 1'b1;
        rd_reg(ADDR_RESULT);
        chk("frozen result", 16'h5678, rd);
        chk("telegram result", 16'h0a0a, telegram_out.result);
        @(posedge core_clk);
        #1;
        chk("rdata after read", 16'h0000, reg_rdata);
        $display("test clock enable done");
        stop_test;
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        stop_test;
    end
endmodule
